/* File: rtl/ckg_pkg.sv */
// Constants for the clock generator control bank at byte offsets 1Ch to 21h.
// Assumes an 8-bit register port driven by the serial protocol engine.
package ckg_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int WD_T0_MS = 250;
  localparam int WD_T1_MS = 500;
  localparam int WD_T2_MS = 2000;
  localparam int WD_T3_MS = 4000;
  localparam int WD_CYC0 = WD_T0_MS * CYC_PER_MS;
  localparam int WD_CYC1 = WD_T1_MS * CYC_PER_MS;
  localparam int WD_CYC2 = WD_T2_MS * CYC_PER_MS;
  localparam int WD_CYC3 = WD_T3_MS * CYC_PER_MS;
  localparam int WD_CNT_W = 32;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int NUM_REGS = 6;
  localparam logic [7:0] OFS_BASE = 8'h1C;
  localparam logic [7:0] OFS_PLL_OP = 8'h1C;
  localparam logic [7:0] OFS_OUT_CTL = 8'h1D;
  localparam logic [7:0] OFS_PIN_FN = 8'h1E;
  localparam logic [7:0] OFS_LOOP = 8'h1F;
  localparam logic [7:0] OFS_WDOG = 8'h20;
  localparam logic [7:0] OFS_POL = 8'h21;
  localparam int IDX_PLL_OP = 0;
  localparam int IDX_OUT_CTL = 1;
  localparam int IDX_PIN_FN = 2;
  localparam int IDX_LOOP = 3;
  localparam int IDX_WDOG = 4;
  localparam int IDX_POL = 5;
  localparam logic [7:0] RST_VAL [NUM_REGS] = '{8'h3F, 8'h33, 8'h90, 8'h84, 8'h80, 8'hB0};
  // Writable bits; the rest hold their reset value
  localparam logic [7:0] WMASK [NUM_REGS] = '{8'hFF, 8'hFF, 8'hE3, 8'h0E, 8'h1E, 8'h03};
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int B_HRS = 7;
  localparam int B_REFSEL = 6;
  localparam int B_C_PD = 5;
  localparam int B_C_LCK = 4;
  localparam int B_B_PD = 3;
  localparam int B_B_LCK = 2;
  localparam int B_A_PD = 1;
  localparam int B_A_LCK = 0;
  localparam int B_DA_GOV = 7;
  localparam int B_DB_GOV = 6;
  localparam int B_DA_EN = 5;
  localparam int B_DB_EN = 4;
  localparam int B_DIV4_SRC = 3;
  localparam int B_SE_SLEW = 2;
  localparam int B_VDD_HI = 1;
  localparam int B_VDD_LO = 0;
  localparam int B_SE_EN = 7;
  localparam int B_FN_HI = 6;
  localparam int B_FN_LO = 5;
  localparam int B_SW_HI = 1;
  localparam int B_SW_LO = 0;
  localparam int B_ORDER = 3;
  localparam int B_CH2 = 2;
  localparam int B_POLE = 1;
  localparam int B_DYNAMIC_FREQ_ENABLE = 4;
  localparam int B_WATCHDOG_ENABLE = 3;
  localparam int B_WD_HI = 2;
  localparam int B_WD_LO = 1;
  localparam int B_ALARM = 0;
  localparam int B_DA_FLIP = 1;
  localparam int B_DB_FLIP = 0;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [1:0] PIN_SE_OE = 2'h0;
  localparam logic [1:0] PIN_PWR_DOWN = 2'h1;
  localparam logic [1:0] PIN_POWER_SAVE = 2'h2;
  localparam logic [1:0] PIN_FREQ_SEL = 2'h3;
  localparam logic [1:0] SUPPLY_1V8 = 2'h3;
  localparam logic [2:0] SPREAD_SHIFT_HI = 3'h4;
  localparam logic [2:0] SPREAD_SHIFT_LO = 3'h0;
  localparam logic [1:0] FREQ_IDLE = 2'h0;
  localparam int NUM_PINS = 2;
  localparam logic PIN_IDLE_LVL = 1'b1;

endpackage : ckg_pkg

/* File: rtl/ckg_wdog.sv */
// Watchdog timer with a sticky alarm flag.
// Assumes mclk, a synchronised active-low reset and a shared clock enable.
`timescale 1ns/1ns
module ckg_wdog #(
  parameter int CYC0 = ckg_pkg::WD_CYC0,
  parameter int CYC1 = ckg_pkg::WD_CYC1,
  parameter int CYC2 = ckg_pkg::WD_CYC2,
  parameter int CYC3 = ckg_pkg::WD_CYC3
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic enable,
  input wire logic [1:0] period_sel,
  input wire logic restart,
  output logic alarm_r
);

  logic [ckg_pkg::WD_CNT_W-1:0] cnt_r;
  logic [ckg_pkg::WD_CNT_W-1:0] limit;
  logic expire;

  // ----------------------------------------
  // Period select
  // ----------------------------------------
  always_comb begin
    case (period_sel)
      2'h0: limit = ckg_pkg::WD_CNT_W'(CYC0);
      2'h1: limit = ckg_pkg::WD_CNT_W'(CYC1);
      2'h2: limit = ckg_pkg::WD_CNT_W'(CYC2);
      default: limit = ckg_pkg::WD_CNT_W'(CYC3);
    endcase
  end

  assign expire = enable && !restart && !alarm_r && (cnt_r == limit - 1'b1);

  // ----------------------------------------
  // Counter and alarm
  // ----------------------------------------
  // Counter is held at zero once alarmed so it cannot wrap past the limit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (clk_en) begin
      if (!enable || restart || alarm_r) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_r <= 1'b0;
    end else if (clk_en) begin
      if (!enable) begin
        alarm_r <= 1'b0;
      end else if (expire) begin
        alarm_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  alarm_on_expiry_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(alarm_r) |-> $past(enable) && ($past(cnt_r) == $past(limit) - 1'b1))
    else $error("alarm set before the period elapsed");

  alarm_disable_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && !enable) |=> !alarm_r)
    else $error("alarm not cleared by disable");

endmodule : ckg_wdog

/* File: rtl/ckg_regs.sv */
// Control register bank: PLL power and lock, outputs, pin function,
// frequency select, watchdog and differential polarity.
// Assumes a byte register port from the serial engine on mclk, and two
// asynchronous output-enable pins.
`timescale 1ns/1ns
module ckg_regs #(
  parameter int WD_CYC0 = ckg_pkg::WD_CYC0,
  parameter int WD_CYC1 = ckg_pkg::WD_CYC1,
  parameter int WD_CYC2 = ckg_pkg::WD_CYC2,
  parameter int WD_CYC3 = ckg_pkg::WD_CYC3
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic oe1_pin,
  input wire logic oe2_pin,
  output logic pll_a_run_n_powerdown,
  output logic pll_a_lock_use,
  output logic pll_b_run_n_powerdown,
  output logic pll_b_lock_use,
  output logic pll_c_run_n_powerdown,
  output logic pll_c_lock_use,
  output logic pll_b_high_res_spread_en,
  output logic [2:0] pll_b_step_shift,
  output logic pll_b_reference_select,
  output logic pll_b_loop_order,
  output logic pll_b_channel_two_enable,
  output logic pll_b_extra_pole_enable,
  output logic fourth_divider_source,
  output logic single_ended_a_slew,
  output logic [1:0] output_supply_level,
  output logic diff_a_out_on,
  output logic diff_b_out_on,
  output logic se_a_out_on,
  output logic power_down_req,
  output logic single_ended_power_saving,
  output logic dynamic_freq_active,
  output logic [1:0] freq_step_select,
  output logic diff_a_complement_polarity,
  output logic diff_b_complement_polarity,
  output logic watchdog_alarm
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Three stages; a level is taken only when stages two and three agree
  logic [ckg_pkg::NUM_PINS-1:0] pin_in;
  logic [ckg_pkg::NUM_PINS-1:0] pin_s1_r;
  logic [ckg_pkg::NUM_PINS-1:0] pin_s2_r;
  logic [ckg_pkg::NUM_PINS-1:0] pin_s3_r;
  logic [ckg_pkg::NUM_PINS-1:0] pin_lvl_r;
  logic oe1_lvl;
  logic oe2_lvl;

  assign pin_in = {oe2_pin, oe1_pin};

  for (genvar p = 0; p < ckg_pkg::NUM_PINS; p++) begin : g_pin
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        pin_s1_r[p] <= ckg_pkg::PIN_IDLE_LVL;
        pin_s2_r[p] <= ckg_pkg::PIN_IDLE_LVL;
        pin_s3_r[p] <= ckg_pkg::PIN_IDLE_LVL;
        pin_lvl_r[p] <= ckg_pkg::PIN_IDLE_LVL;
      end else if (clk_en) begin
        pin_s1_r[p] <= pin_in[p];
        pin_s2_r[p] <= pin_s1_r[p];
        pin_s3_r[p] <= pin_s2_r[p];
        if (pin_s2_r[p] == pin_s3_r[p]) begin
          pin_lvl_r[p] <= pin_s3_r[p];
        end
      end
    end
  end

  assign oe1_lvl = pin_lvl_r[0];
  assign oe2_lvl = pin_lvl_r[1];

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] reg_r [ckg_pkg::NUM_REGS];
  logic [7:0] idx;
  logic hit;
  logic [7:0] rd_val;

  assign idx = reg_addr - ckg_pkg::OFS_BASE;
  assign hit = idx < 8'(ckg_pkg::NUM_REGS);

  // Masked write: reserved and read-only bits are rebuilt from reset values
  for (genvar i = 0; i < ckg_pkg::NUM_REGS; i++) begin : g_reg
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        reg_r[i] <= ckg_pkg::RST_VAL[i];
      end else if (clk_en && reg_wr && hit && idx == 8'(i)) begin
        reg_r[i] <= (reg_wdata & ckg_pkg::WMASK[i]) |
                    (ckg_pkg::RST_VAL[i] & ~ckg_pkg::WMASK[i]);
      end
    end
  end

  always_comb begin
    rd_val = ckg_pkg::RD_UNMAPPED;
    if (hit) begin
      rd_val = reg_r[idx[2:0]];
    end
    if (reg_addr == ckg_pkg::OFS_WDOG) begin
      rd_val[ckg_pkg::B_ALARM] = watchdog_alarm;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= rd_val;
    end
  end

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  logic [7:0] r_op;
  logic [7:0] r_out;
  logic [7:0] r_fn;
  logic [7:0] r_loop;
  logic [7:0] r_wd;
  logic [7:0] r_pol;
  logic [1:0] pin_fn;

  assign r_op = reg_r[ckg_pkg::IDX_PLL_OP];
  assign r_out = reg_r[ckg_pkg::IDX_OUT_CTL];
  assign r_fn = reg_r[ckg_pkg::IDX_PIN_FN];
  assign r_loop = reg_r[ckg_pkg::IDX_LOOP];
  assign r_wd = reg_r[ckg_pkg::IDX_WDOG];
  assign r_pol = reg_r[ckg_pkg::IDX_POL];
  assign pin_fn = r_fn[ckg_pkg::B_FN_HI:ckg_pkg::B_FN_LO];

  // Straight register bits
  assign pll_a_run_n_powerdown = r_op[ckg_pkg::B_A_PD];
  assign pll_a_lock_use = r_op[ckg_pkg::B_A_LCK];
  assign pll_b_run_n_powerdown = r_op[ckg_pkg::B_B_PD];
  assign pll_b_lock_use = r_op[ckg_pkg::B_B_LCK];
  assign pll_c_run_n_powerdown = r_op[ckg_pkg::B_C_PD];
  assign pll_c_lock_use = r_op[ckg_pkg::B_C_LCK];
  assign pll_b_high_res_spread_en = r_op[ckg_pkg::B_HRS];
  assign pll_b_reference_select = r_op[ckg_pkg::B_REFSEL];
  assign fourth_divider_source = r_out[ckg_pkg::B_DIV4_SRC];
  assign single_ended_a_slew = r_out[ckg_pkg::B_SE_SLEW];
  assign output_supply_level = r_out[ckg_pkg::B_VDD_HI:ckg_pkg::B_VDD_LO];
  assign pll_b_loop_order = r_loop[ckg_pkg::B_ORDER];
  assign pll_b_channel_two_enable = r_loop[ckg_pkg::B_CH2];
  assign pll_b_extra_pole_enable = r_loop[ckg_pkg::B_POLE];
  assign diff_a_complement_polarity = r_pol[ckg_pkg::B_DA_FLIP];
  assign diff_b_complement_polarity = r_pol[ckg_pkg::B_DB_FLIP];

  // ----------------------------------------
  // Derived controls
  // ----------------------------------------
  logic pd_nxt;

  assign pd_nxt = (pin_fn == ckg_pkg::PIN_PWR_DOWN) && !oe1_lvl;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pll_b_step_shift <= ckg_pkg::SPREAD_SHIFT_LO;
    end else if (clk_en) begin
      pll_b_step_shift <= r_op[ckg_pkg::B_HRS] ? ckg_pkg::SPREAD_SHIFT_HI :
                          ckg_pkg::SPREAD_SHIFT_LO;
    end
  end

  // Output gating; one cycle behind the register write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      diff_a_out_on <= 1'b0;
      diff_b_out_on <= 1'b0;
    end else if (clk_en) begin
      diff_a_out_on <= r_out[ckg_pkg::B_DA_EN] &&
                       (!r_out[ckg_pkg::B_DA_GOV] || oe2_lvl);
      diff_b_out_on <= r_out[ckg_pkg::B_DB_EN] &&
                       (!r_out[ckg_pkg::B_DB_GOV] || oe2_lvl);
    end
  end

  // Power-down pin beats the single-ended output enable only; the differential outputs ignore it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      se_a_out_on <= 1'b0;
      power_down_req <= 1'b0;
      single_ended_power_saving <= 1'b0;
    end else if (clk_en) begin
      se_a_out_on <= r_fn[ckg_pkg::B_SE_EN] && !pd_nxt &&
                     (pin_fn != ckg_pkg::PIN_SE_OE || oe1_lvl);
      power_down_req <= pd_nxt;
      single_ended_power_saving <= (pin_fn == ckg_pkg::PIN_POWER_SAVE) && !oe1_lvl;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dynamic_freq_active <= 1'b0;
      freq_step_select <= ckg_pkg::FREQ_IDLE;
    end else if (clk_en) begin
      dynamic_freq_active <= r_wd[ckg_pkg::B_DYNAMIC_FREQ_ENABLE];
      if (!r_wd[ckg_pkg::B_DYNAMIC_FREQ_ENABLE]) begin
        freq_step_select <= ckg_pkg::FREQ_IDLE;
      end else if (pin_fn == ckg_pkg::PIN_FREQ_SEL) begin
        freq_step_select <= {r_fn[ckg_pkg::B_SW_HI], oe1_lvl};
      end else begin
        freq_step_select <= r_fn[ckg_pkg::B_SW_HI:ckg_pkg::B_SW_LO];
      end
    end
  end

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // Any taken register write restarts the period
  ckg_wdog #(
    .CYC0(WD_CYC0),
    .CYC1(WD_CYC1),
    .CYC2(WD_CYC2),
    .CYC3(WD_CYC3)
  ) u_wdog (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .enable(r_wd[ckg_pkg::B_WATCHDOG_ENABLE]),
    .period_sel(r_wd[ckg_pkg::B_WD_HI:ckg_pkg::B_WD_LO]),
    .restart(reg_wr),
    .alarm_r(watchdog_alarm)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence diff_a_off_wr_s;
    clk_en && reg_wr && reg_addr == ckg_pkg::OFS_OUT_CTL && !reg_wdata[ckg_pkg::B_DA_EN];
  endsequence

  pll_reset_on_a: assert property (@(posedge mclk)
    ($past(!rst_n) && rst_n) |-> (r_op == ckg_pkg::RST_VAL[ckg_pkg::IDX_PLL_OP]))
    else $error("PLL control not at reset value");

  diff_a_disable_a: assert property (@(posedge mclk) disable iff (!rst_n)
    diff_a_off_wr_s ##1 clk_en |=> !diff_a_out_on)
    else $error("differential output stayed on after disable");

  diff_gov_a: assert property (@(posedge mclk) disable iff (!rst_n)
    diff_b_out_on |-> $past(r_out[ckg_pkg::B_DB_EN]) &&
      (!$past(r_out[ckg_pkg::B_DB_GOV]) || $past(oe2_lvl)))
    else $error("differential output on without permission");

  spread_shift_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && reg_wr && reg_addr == ckg_pkg::OFS_PLL_OP && reg_wdata[ckg_pkg::B_HRS])
      ##1 clk_en |=> pll_b_step_shift == ckg_pkg::SPREAD_SHIFT_HI)
    else $error("spread step not shifted by four");

  pin_powerdown_a: assert property (@(posedge mclk) disable iff (!rst_n)
    power_down_req |-> !se_a_out_on && $past(pin_fn) == ckg_pkg::PIN_PWR_DOWN)
    else $error("power-down request with wrong pin function");

  freq_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !dynamic_freq_active |-> freq_step_select == ckg_pkg::FREQ_IDLE)
    else $error("frequency select moved while disabled");

  alarm_readback_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && reg_rd && reg_addr == ckg_pkg::OFS_WDOG)
      |=> reg_rdata[ckg_pkg::B_ALARM] == $past(watchdog_alarm))
    else $error("alarm flag read back wrong");

  reserved_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && reg_rd && reg_addr == ckg_pkg::OFS_POL)
      |=> reg_rdata[7:2] == ckg_pkg::RST_VAL[ckg_pkg::IDX_POL][7:2])
    else $error("reserved bits changed");

endmodule : ckg_regs

/* File: tb/ckg_host.sv */
// Host model for the byte register port: writes, reads and idle gaps.
// Assumes the register port of ckg_regs, sampled on rising mclk.
`timescale 1ns/1ns
module ckg_host (
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // ----------------------------------------
  // Idle bus
  // ----------------------------------------
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // ----------------------------------------
  // Transfers
  // ----------------------------------------
  // Released lines show the inverse, so a stale value never passes for data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge mclk);
    d = reg_rdata;
  endtask : rd

  // Slow host: leaves the port idle for n cycles
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle
endmodule : ckg_host

/* File: tb/ckg_regs_tb_top.sv */
// Self-checking bench for the control register bank.
// Assumes ckg_regs and ckg_host; watchdog periods shortened by parameter.
`timescale 1ns/1ns
module ckg_regs_tb_top;
  localparam int C0 = 20;
  localparam int C1 = 40;
  localparam int C2 = 80;
  localparam int C3 = 160;
  logic mclk, rst_b, clk_en, oe1_pin, oe2_pin;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd;
  wire [7:0] pll_bits;
  wire [2:0] shift, loop3;
  wire [3:0] out4;
  wire [1:0] pol, fsel;
  wire da_on, db_on, se_on, pd, pps, dfa, alarm;
  wire [27:0] seen_all = {pll_bits, shift, loop3, out4, pol, da_on, db_on, se_on, pd, pps,
                          dfa, fsel};
  logic [7:0] sh [6];
  logic [23:0] rows [22] = '{24'h1C0000, 24'h1CC0C0, 24'h1C5A5A, 24'h1DCCCC, 24'h1D0000,
    24'h1D3333, 24'h1EFFF3, 24'h1E0010, 24'h1FFF8E, 24'h1F0080, 24'h1F8484, 24'h200180,
    24'h201796, 24'h200080, 24'h21FFB3, 24'h2100B0, 24'h22FF00, 24'h1B5A00, 24'hFF0000,
    24'h1C3F3F, 24'h1D3333, 24'h1E9090};
  int num_errors = 0;
  int check_count = 0;
  int n, lim;
  logic [3:0] i4;

  ckg_host u_host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  ckg_regs #(.WD_CYC0(C0), .WD_CYC1(C1), .WD_CYC2(C2), .WD_CYC3(C3)) u_dut (
    .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .oe1_pin(oe1_pin), .oe2_pin(oe2_pin),
    .pll_a_run_n_powerdown(pll_bits[1]), .pll_a_lock_use(pll_bits[0]),
    .pll_b_run_n_powerdown(pll_bits[3]), .pll_b_lock_use(pll_bits[2]),
    .pll_c_run_n_powerdown(pll_bits[5]), .pll_c_lock_use(pll_bits[4]),
    .pll_b_high_res_spread_en(pll_bits[7]), .pll_b_step_shift(shift),
    .pll_b_reference_select(pll_bits[6]), .pll_b_loop_order(loop3[2]),
    .pll_b_channel_two_enable(loop3[1]), .pll_b_extra_pole_enable(loop3[0]),
    .fourth_divider_source(out4[3]), .single_ended_a_slew(out4[2]),
    .output_supply_level(out4[1:0]), .diff_a_out_on(da_on), .diff_b_out_on(db_on),
    .se_a_out_on(se_on), .power_down_req(pd), .single_ended_power_saving(pps),
    .dynamic_freq_active(dfa), .freq_step_select(fsel),
    .diff_a_complement_polarity(pol[1]), .diff_b_complement_polarity(pol[0]),
    .watchdog_alarm(alarm));

  // ----------------------------------------
  // Clock, checking and verdict
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // Worst case is well under 5000 cycles
  initial begin
    #(40 * 20000);
    num_errors++;
    wrap_up();
  end

  // ----------------------------------------
  // Expected outputs from the shadow registers
  // ----------------------------------------
  function automatic logic [27:0] exp_all(input logic o1, input logic o2);
    logic [1:0] fn, fs;
    logic p_d, p_s, en;
    fn = sh[2][6:5];
    p_d = (fn == 2'h1) && !o1;
    p_s = (fn == 2'h2) && !o1;
    en = sh[4][4];
    fs = !en ? 2'h0 : (fn == 2'h3) ? {sh[2][1], o1} : sh[2][1:0];
    return {sh[0], sh[0][7] ? 3'h4 : 3'h0, sh[3][3:1], sh[1][3:0], sh[5][1:0],
      sh[1][5] & (!sh[1][7] | o2), sh[1][4] & (!sh[1][6] | o2),
      sh[2][7] & !p_d & ((fn != 2'h0) | o1), p_d, p_s, en, fs};
  endfunction : exp_all

  task automatic reset_shadow();
    sh = '{8'h3F, 8'h33, 8'h90, 8'h84, 8'h80, 8'hB0};
  endtask : reset_shadow

  // Write, read back and compare every output but the watchdog alarm against the shadow
  task automatic wr_chk(input logic [7:0] a, input logic [7:0] w, input logic [7:0] r);
    logic [27:0] exp_v;
    u_host.wr(a, w);
    if (a >= 8'h1C && a <= 8'h21) begin
      sh[a - 8'h1C] = r;
    end
    u_host.rd(a, d);
    check(d, r);
    exp_v = exp_all(oe1_pin, oe2_pin);
    check(seen_all[27:20], exp_v[27:20]);
    check(seen_all[19:14], exp_v[19:14]);
    check(seen_all[13:10], exp_v[13:10]);
    check(seen_all[9:8], exp_v[9:8]);
    check(seen_all[7:6], exp_v[7:6]);
    check(seen_all[5:0], exp_v[5:0]);
  endtask : wr_chk

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    oe1_pin = 1'b1;
    oe2_pin = 1'b1;
    reset_shadow();
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 6; i++) begin
      u_host.rd(8'h1C + 8'(i), d);
      check(d, sh[i]);
    end
    check(seen_all, exp_all(1'b1, 1'b1));
    foreach (rows[i]) begin
      wr_chk(rows[i][23:16], rows[i][15:8], rows[i][7:0]);
    end
    // Pin functions, frequency select and second enable; sync needs ~5 edges
    wr_chk(8'h1D, 8'hF3, 8'hF3);
    wr_chk(8'h20, 8'h10, 8'h90);
    for (int i = 0; i < 16; i++) begin
      i4 = 4'(i);
      @(negedge mclk);
      oe2_pin = i4[3];
      oe1_pin = i4[0];
      u_host.idle(8);
      wr_chk(8'h1E, {1'b1, i4[2:1], 3'h0, i4[3:2]}, {1'b1, i4[2:1], 3'h4, i4[3:2]});
    end
    // Watchdog periods, sticky alarm and clearing by disable
    for (int p = 0; p < 4; p++) begin
      lim = (p == 0) ? C0 : (p == 1) ? C1 : (p == 2) ? C2 : C3;
      u_host.wr(8'h20, 8'h08 | 8'(p << 1));
      n = 0;
      while (alarm !== 1'b1 && n < 400) begin
        @(negedge mclk);
        n++;
      end
      check(32'((n >= lim - 2) && (n <= lim + 1)), 32'h1);
      u_host.idle(30);
      u_host.wr(8'h1D, 8'hF3);
      u_host.rd(8'h20, d);
      check(d, 8'h89 | 8'(p << 1));
      wr_chk(8'h20, 8'h01, 8'h80);
      check(alarm, 1'b0);
    end
    // Any write restarts the count, so no alarm while writes keep coming
    u_host.wr(8'h20, 8'h08);
    repeat (6) begin
      u_host.idle(10);
      u_host.wr(8'h1C, sh[0]);
    end
    check(alarm, 1'b0);
    u_host.wr(8'h20, 8'h00);
    // Frozen clock enable drops the write
    @(negedge mclk);
    clk_en = 1'b0;
    u_host.wr(8'h1C, 8'h00);
    clk_en = 1'b1;
    u_host.rd(8'h1C, d);
    check(d, sh[0]);
    // Reset in mid-run with the alarm raised
    u_host.wr(8'h20, 8'h08);
    u_host.wr(8'h1D, 8'h00);
    u_host.idle(30);
    rst_b = 1'b0;
    reset_shadow();
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    repeat (3) @(posedge mclk);
    check(alarm, 1'b0);
    u_host.rd(8'h1D, d);
    check(d, 8'h33);
    u_host.rd(8'h20, d);
    check(d, 8'h80);
    check(seen_all, exp_all(oe1_pin, oe2_pin));
    wrap_up();
  end
endmodule : ckg_regs_tb_top
